/* design/hw_reset_pkg.sv */
// constants and carrier types for the hardware reset sequencer
package hw_reset_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
  localparam int unsigned REJECT_TIME_NS   = 5_000;
  localparam int unsigned ACCEPT_TIME_NS   = 9_000;
  localparam int unsigned MIN_LOW_TIME_NS  = 10_000;
  localparam int unsigned CANCEL_SLEEP_IN_MS  = 5;
  localparam int unsigned CANCEL_SLEEP_OUT_MS = 120;
  localparam int unsigned BLANK_MAX_MS     = 120;
  localparam int unsigned CMD_WAIT_MS      = 5;
  localparam int unsigned SLEEP_OUT_WAIT_MS = 120;
  // glitch limit lies between reject and accept; round up so 5 us is always rejected
  localparam int unsigned QUAL_CYCLES =
    (((REJECT_TIME_NS + ACCEPT_TIME_NS) / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CANCEL_SLEEP_IN_CYCLES  = (CANCEL_SLEEP_IN_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int unsigned CANCEL_SLEEP_OUT_CYCLES = (CANCEL_SLEEP_OUT_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYCLES     = (BLANK_MAX_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int unsigned NVM_WORDS        = 4;
  localparam int unsigned NVM_ADDR_W       = 2;
  localparam logic [7:0]  NVM_RESET_DATA   = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [1:0] addr;
    logic [7:0] data;
  } nvm_word_s;
endpackage : hw_reset_pkg

/* design/reset_glitch_filter.sv */
// counts steady cycles before accepting a level change on the reset pin
`timescale 1ns/1ps
module reset_glitch_filter
  import hw_reset_pkg::*;
#(
  parameter int unsigned QUAL = QUAL_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic clk_en_i,
  input  wire logic pin_n_i,
  output logic      filt_n_o
);
  if (QUAL < 2)
  begin : g_chk_qual
    $error("QUAL too small");
  end
  localparam int unsigned CW = $clog2(QUAL + 1);
  logic [CW-1:0] cnt_reg;
  logic          filt_reg;
  wire           differs = (pin_n_i != filt_reg);
  wire           done    = (cnt_reg == CW'(QUAL - 1));
  assign filt_n_o = filt_reg;
  // same filter both ways: short low pulses and short high spikes are rejected
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_reg  <= '0;
      filt_reg <= 1'b1;
    end
    else if (clk_en_i)
    begin
      cnt_reg  <= (differs && !done) ? cnt_reg + CW'(1) : '0;
      if (differs && done)
        filt_reg <= pin_n_i;
    end
endmodule : reset_glitch_filter

/* design/display_hw_reset_sequencer.sv */
// hardware reset sequencer: filters the reset pin, blanks, reloads nvm, times reset cancel
`timescale 1ns/1ps
module display_hw_reset_sequencer
  import hw_reset_pkg::*;
#(
  parameter int unsigned QUAL        = QUAL_CYCLES,
  parameter int unsigned CANCEL_IN   = CANCEL_SLEEP_IN_CYCLES,
  parameter int unsigned CANCEL_OUT  = CANCEL_SLEEP_OUT_CYCLES,
  parameter int unsigned BLANK       = BLANK_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       hw_reset_n_i,
  input  wire logic       sleep_out_i,
  input  wire logic [7:0] nvm_data_i,
  output logic            nvm_rd_o,
  output logic [1:0]      nvm_addr_o,
  output nvm_word_s       reg_load_o,
  output logic            blank_o,
  output logic            defaults_o,
  output logic            cmd_ready_o
);
  // timers are 23 bits wide and the load must fit inside the shortest cancel window
  if (QUAL < 2)
  begin : g_chk_qual
    $error("QUAL must be at least 2");
  end
  if (CANCEL_OUT >= (1 << 23))
  begin : g_chk_width
    $error("CANCEL_OUT does not fit the 23 bit timer");
  end
  if (CANCEL_IN < QUAL + NVM_WORDS + 4)
  begin : g_chk_in
    $error("CANCEL_IN too short for filter and load");
  end
  if (CANCEL_OUT < CANCEL_IN)
  begin : g_chk_out
    $error("CANCEL_OUT below CANCEL_IN");
  end
  if (BLANK < 1 || BLANK + NVM_WORDS + 4 > CANCEL_OUT)
  begin : g_chk_blank
    $error("BLANK outside the sleep-out cancel window");
  end

  typedef enum {ST_RUN, ST_BLANK, ST_HELD, ST_LOAD, ST_WAIT} state_e;
  state_e      state_reg;
  state_e      state_next;

  logic        filt_n;
  logic [22:0] tmr_reg;
  logic [22:0] tmr_next;
  logic [22:0] blk_reg;
  logic [22:0] blk_next;
  logic        slp_out_reg;
  logic        slp_out_next;
  logic [1:0]  addr_reg;
  logic [1:0]  addr_next;
  logic        rd_reg;
  logic        rd_next;
  nvm_word_s   load_reg;
  nvm_word_s   load_next;
  logic        blank_reg;
  logic        blank_next;
  logic        dflt_reg;
  logic        dflt_next;
  logic        rdy_reg;
  logic        rdy_next;

  reset_glitch_filter #(.QUAL(QUAL)) u_filt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .pin_n_i    (hw_reset_n_i),
    .filt_n_o   (filt_n)
  );

  // a new reset is only taken outside blank/held, so spikes there cannot restart it
  wire        fell       = !filt_n && state_reg != ST_BLANK && state_reg != ST_HELD;
  wire [22:0] cancel_lim = slp_out_reg ? 23'(CANCEL_OUT) : 23'(CANCEL_IN);
  // timer starts at the filtered release, which lags the pin by the filter length
  wire [22:0] exit_at    = cancel_lim - 23'(QUAL + 1);
  wire        wait_done  = tmr_reg >= exit_at;
  wire        blank_done = !slp_out_reg || blk_reg >= 23'(BLANK - 1);
  wire        load_last  = addr_reg == 2'(NVM_WORDS - 1);
  wire [22:0] tmr_inc    = tmr_reg + 23'(1);
  // release may come during blanking, so the cancel timer already runs there
  wire [22:0] tmr_rel    = filt_n ? tmr_inc : '0;
  assign load_next.valid = rd_reg;
  assign load_next.addr  = addr_reg;
  assign load_next.data  = nvm_data_i;

  always_comb
  begin
    state_next   = state_reg;
    tmr_next     = tmr_reg;
    blk_next     = blk_reg;
    slp_out_next = slp_out_reg;
    addr_next    = addr_reg;
    rd_next      = 1'b0;
    blank_next   = blank_reg;
    dflt_next    = 1'b0;
    rdy_next     = 1'b0;
    if (fell)
    begin
      // mode latched at assertion picks the cancel limit
      state_next   = ST_BLANK;
      slp_out_next = sleep_out_i;
      tmr_next     = '0;
      blk_next     = '0;
      blank_next   = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_RUN:
        begin
          rdy_next = 1'b1;
        end
        ST_BLANK:
        begin
          // full blanking sequence from sleep-out, none from sleep
          blk_next = blk_reg + 23'(!blank_done);
          tmr_next = tmr_rel;
          if (blank_done)
          begin
            state_next = ST_HELD;
          end
        end
        ST_HELD:
        begin
          tmr_next = tmr_rel;
          if (filt_n)
          begin
            // every release reloads the stored words
            state_next = ST_LOAD;
            addr_next  = '0;
            rd_next    = 1'b1;
          end
        end
        ST_LOAD:
        begin
          tmr_next = tmr_inc;
          if (load_last)
          begin
            state_next = ST_WAIT;
          end
          else
          begin
            addr_next = addr_reg + 2'(1);
            rd_next   = 1'b1;
          end
        end
        ST_WAIT:
        begin
          tmr_next = tmr_inc;
          if (wait_done)
          begin
            state_next = ST_RUN;
            blank_next = 1'b0;
            dflt_next  = 1'b1;
            rdy_next   = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      state_reg   <= ST_BLANK;
      tmr_reg     <= '0;
      blk_reg     <= '0;
      slp_out_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_reg   <= state_next;
      tmr_reg     <= tmr_next;
      blk_reg     <= blk_next;
      slp_out_reg <= slp_out_next;
    end

  // nvm read path kept apart from the control registers
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      addr_reg <= '0;
      rd_reg   <= 1'b0;
      load_reg <= '0;
    end
    else if (clk_en_i)
    begin
      addr_reg <= addr_next;
      rd_reg   <= rd_next;
      load_reg <= load_next;
    end

  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      blank_reg <= 1'b1;
      dflt_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      blank_reg <= blank_next;
      dflt_reg  <= dflt_next;
      rdy_reg   <= rdy_next;
    end

  assign nvm_rd_o    = rd_reg;
  assign nvm_addr_o  = addr_reg;
  assign reg_load_o  = load_reg;
  assign blank_o     = blank_reg;
  assign defaults_o  = dflt_reg;
  assign cmd_ready_o = rdy_reg;
endmodule : display_hw_reset_sequencer

/* verification/seq_chk.sv */
// port assertions for the reset sequencer
`timescale 1ns/1ps
module seq_chk
  import hw_reset_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       clk_en_i,
  input wire logic       hw_reset_n_i,
  input wire logic       nvm_rd_o,
  input wire logic       blank_o,
  input wire logic       defaults_o,
  input wire logic       cmd_ready_o,
  input wire logic [1:0] nvm_addr_o,
  input wire nvm_word_s  reg_load_o
);
  default clocking @(posedge core_clk_i); endclocking
  // a frozen block keeps still, so timing properties are disabled and running attempts dropped while it is frozen
  default disable iff (rst_i || !clk_en_i);
  property p_load; nvm_rd_o |=> reg_load_o.valid && reg_load_o.addr == $past(nvm_addr_o); endproperty
  a_load: assert property (p_load) else $error("load lost");
  property p_rd4; nvm_rd_o && nvm_addr_o == 2'h0 |=> nvm_rd_o && nvm_addr_o == 2'h1
    ##1 nvm_addr_o == 2'h2 ##1 nvm_addr_o == 2'h3 ##1 !nvm_rd_o; endproperty
  a_rd4: assert property (p_rd4) else $error("read order");
  property p_excl; cmd_ready_o |-> !blank_o; endproperty
  a_excl: assert property (p_excl) else $error("ready while blank");
  property p_def; $rose(cmd_ready_o) |-> defaults_o && $fell(blank_o); endproperty
  a_def: assert property (p_def) else $error("no defaults");
  property p_glitch; (cmd_ready_o && !hw_reset_n_i) [*3] ##1 hw_reset_n_i |=> cmd_ready_o; endproperty
  a_glitch: assert property (p_glitch) else $error("ready lost");
  property p_cut; !hw_reset_n_i [*8] |=> blank_o && !cmd_ready_o; endproperty
  a_cut: assert property (p_cut) else $error("reset missed");
  property p_min; $rose(blank_o) |-> !cmd_ready_o [*8]; endproperty
  a_min: assert property (p_min) else $error("cancel short");
  property p_bound; nvm_rd_o && nvm_addr_o == 2'h0 |-> ##[1:120] (cmd_ready_o || !hw_reset_n_i); endproperty
  a_bound: assert property (p_bound) else $error("cancel long");
  c_rdy: cover property ($rose(cmd_ready_o));
  c_blank: cover property ($rose(blank_o));
  c_last: cover property (nvm_rd_o && nvm_addr_o == 2'h3);
endmodule : seq_chk

/* verification/nvm_model.sv */
// nvm content model behind the load port
`timescale 1ns/1ps
module nvm_model
  import hw_reset_pkg::*;
(
  input  wire logic [1:0] addr_i,
  output logic [7:0]      data_o
);
  // distinct word per address so a swap shows
  assign data_o = 8'hA0 | {6'h00, addr_i};
endmodule : nvm_model

/* verification/tb_top.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module tb_top;
  import hw_reset_pkg::*;
  localparam int unsigned Q = 4, CI = 20, CO = 60, BL = 30;
  logic clk = 0, rst = 1, pin_n = 1, slp = 0, en = 1, rd, blank, dflt, rdy;
  logic [7:0] nd;
  logic [1:0] na;
  nvm_word_s  ld;
  int err_count = 0, n_checks = 0, cyc = 0, loads = 0, n, l0;
  display_hw_reset_sequencer #(.QUAL(Q), .CANCEL_IN(CI), .CANCEL_OUT(CO), .BLANK(BL)) DUT (
    .core_clk_i(clk), .rst_i(rst), .clk_en_i(en), .hw_reset_n_i(pin_n), .sleep_out_i(slp),
    .nvm_data_i(nd), .nvm_rd_o(rd), .nvm_addr_o(na), .reg_load_o(ld), .blank_o(blank),
    .defaults_o(dflt), .cmd_ready_o(rdy));
  nvm_model NVM (.addr_i(na), .data_o(nd));
  initial forever #10 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin err_count++; $display("[ERR] %s exp %0h seen %0h", nm, exp, got); end
  endtask : chk
  always @(negedge clk)
  begin
    cyc++;
    if (ld.valid === 1'b1)
    begin
      chk("addr", ld.addr, loads[1:0]);
      chk("data", ld.data, 8'hA0 | 8'(loads[1:0]));
      loads++;
    end
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic wait_rdy(int lim);
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin @(negedge clk); n++; end
  endtask : wait_rdy
  task automatic hold_low(int c);
    pin_n = 0;
    repeat (c) @(negedge clk);
    pin_n = 1; // host releases the pin after c cycles low and sends nothing after
  endtask : hold_low
  task automatic t_boot;
    wait_rdy(100);
    chk("boot_time", n > CI / 2 && n <= CI, 1);
    chk("boot_loads", loads, 4);
  endtask : t_boot
  task automatic t_glitch;
    hold_low(3);
    repeat (10) @(negedge clk);
    chk("glitch", rdy, 1);
  endtask : t_glitch
  task automatic t_spike;
    l0 = loads;
    hold_low(10);
    repeat (2) @(negedge clk);
    hold_low(10);
    chk("spike_blank", blank, 1);
    wait_rdy(100);
    chk("spike_loads", loads, l0 + 4);
    chk("spike_time", n > CI / 2 && n <= CI, 1);
  endtask : t_spike
  task automatic t_sleep_out;
    slp = 1;
    hold_low(10);
    wait_rdy(200);
    chk("out_time", n > CO / 2 && n <= CO, 1);
  endtask : t_sleep_out
  task automatic t_freeze;
    en = 0;
    hold_low(10);
    chk("freeze_rdy", rdy, 1);
    en = 1;
    repeat (10) @(negedge clk);
    chk("freeze_blank", blank, 0);
  endtask : t_freeze
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 0;
    t_boot();
    t_glitch();
    t_spike();
    t_sleep_out();
    t_freeze();
    end_sim();
  end
endmodule : tb_top
bind display_hw_reset_sequencer seq_chk CHK (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .hw_reset_n_i(hw_reset_n_i),
  .nvm_rd_o(nvm_rd_o), .blank_o(blank_o), .defaults_o(defaults_o), .cmd_ready_o(cmd_ready_o),
  .nvm_addr_o(nvm_addr_o), .reg_load_o(reg_load_o));
